// file: rtl/bit_sync.sv
`timescale 1ns/10ps
`default_nettype none
module bit_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Data
	input wire logic async_in,
	output logic sync_out
);
	logic stage1;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stage1 <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // bit_sync
`default_nettype wire

// file: rtl/link_regs_pkg.sv
package link_regs_pkg;

	// -----------------------------------------------------------------
	// Register offsets
	// -----------------------------------------------------------------
	localparam logic [7:0] ctrl_offset = 8'h04;
	localparam logic [7:0] status_offset = 8'h08;
	localparam logic [7:0] irq_status_offset = 8'h0C;
	localparam logic [7:0] irq_clear_offset = 8'h10;
	localparam logic [7:0] irq_enable_offset = 8'h14;
	localparam logic [7:0] irq_pointer_offset = 8'h18;

	// -----------------------------------------------------------------
	// Control fields
	// -----------------------------------------------------------------
	localparam int ctrl_soft_reset_bit = 0;
	localparam int ctrl_wrap_bit = 1;
	localparam int ctrl_addr_bit = 2;
	localparam int ctrl_target_bit = 7;
	localparam logic [31:0] ctrl_write_mask = 32'h0000_0087;
	localparam logic [31:0] ctrl_reset = 32'h0000_0000;

	// -----------------------------------------------------------------
	// Status fields
	// -----------------------------------------------------------------
	localparam int st_link_bit = 0;
	localparam int st_near_err_bit = 7;
	localparam int st_far_err_bit = 8;
	localparam int st_out_pause_bit = 9;
	localparam int st_in_pause_bit = 10;
	localparam int st_tuner_bit = 11;
	localparam int st_sample_lo = 12;
	localparam int st_tx_lane_lo = 20;
	localparam int st_rx_lane_lo = 24;
	localparam logic [3:0] lane_count_max = 4'h4;

	// -----------------------------------------------------------------
	// Interrupt event bits
	// -----------------------------------------------------------------
	localparam int ev_near_err = 0;
	localparam int ev_far_err = 1;
	localparam int ev_link_change = 2;
	localparam int ev_width = 3;

	// -----------------------------------------------------------------
	// Link symbols on the serial pin
	// -----------------------------------------------------------------
	localparam logic [7:0] sym_pause_on = 8'hF1;
	localparam logic [7:0] sym_pause_off = 8'hF2;
	localparam logic [7:0] sym_error = 8'hFE;

	typedef struct packed {
		logic target_local;
		logic addr_compress_off;
		logic internal_wrap;
		logic soft_reset;
	} ctrl_type;

	typedef struct packed {
		logic [3:0] rx_lane_count;
		logic [3:0] tx_lane_count;
		logic [2:0] rx_sample_point_now;
		logic link_up;
		logic fifo1_full;
		logic fifo2_full;
		logic inbound_error;
		logic [7:0] rx_byte;
		logic rx_byte_valid;
	} core_status_type;

endpackage

// file: rtl/serial_link_ctrl_status.sv
// Operation
// - ctrl bit7 picks interrupt packet target register
// - reserved bits read zero, writes ignored
// - ctrl bit2 set sends full addresses
// - ctrl bit1 wraps transmit into receive
// - ctrl bit0 resets machines, drops link
// - software reset clears only status register
// - status 27-24 receive lanes, none to four
// - status 23-20 transmit lanes, none to four
// - status 14-12 current receive sample point
// - status bit11 always reads one
// - bit10 set by pause-on, cleared by pause-off
// - bit9 set when inbound FIFO full, pause sent
// - error bits clear only on write one
// - other status read-only, reset zero, tuner one
// - bit0 shows link initialised and alive
// - near error sets bit7, can interrupt
// - far error symbol sets bit8, can interrupt
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module serial_link_ctrl_status (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Serial link pins
	input wire logic link_clk,
	input wire logic link_rx_data,
	output logic link_tx_data,
	// Port core
	input wire link_regs_pkg::core_status_type core_status,
	input wire logic [7:0] tx_byte,
	input wire logic tx_byte_valid,
	output link_regs_pkg::ctrl_type ctrl_out,
	output logic [31:0] irq_pointer,
	output logic core_reset,
	output logic loop_byte_valid,
	output logic [7:0] loop_byte,
	output logic tx_stall,
	output logic [7:0] pause_symbol,
	output logic pause_symbol_valid,
	// Interrupt
	output logic port_irq_out
);
	// -----------------------------------------------------------------
	// Pin synchronisers
	// -----------------------------------------------------------------
	logic link_clk_s;
	logic rx_data_s;
	logic link_clk_d;
	logic link_rise;

	bit_sync clk_sync (
		.clk(clk),
		.resetn(resetn),
		.async_in(link_clk),
		.sync_out(link_clk_s)
	);

	bit_sync data_sync (
		.clk(clk),
		.resetn(resetn),
		.async_in(link_rx_data),
		.sync_out(rx_data_s)
	);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			link_clk_d <= 1'b0;
		end else begin
			link_clk_d <= link_clk_s;
		end
	end

	assign link_rise = link_clk_s & ~link_clk_d;

	// -----------------------------------------------------------------
	// Bus decode
	// -----------------------------------------------------------------
	logic access;
	logic wr;
	logic known;
	link_regs_pkg::ctrl_type ctrl;
	logic status_write;

	assign access = psel & penable;
	assign wr = access & pwrite;
	assign pready = 1'b1;
	assign known = (paddr == link_regs_pkg::ctrl_offset) ||
		(paddr == link_regs_pkg::status_offset) ||
		(paddr == link_regs_pkg::irq_status_offset) ||
		(paddr == link_regs_pkg::irq_clear_offset) ||
		(paddr == link_regs_pkg::irq_enable_offset) ||
		(paddr == link_regs_pkg::irq_pointer_offset);
	assign pslverr = access & ~known;
	assign status_write = wr && (paddr == link_regs_pkg::status_offset);

	// -----------------------------------------------------------------
	// Control register
	// -----------------------------------------------------------------
	logic [31:0] ctrl_word;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_word <= link_regs_pkg::ctrl_reset;
		end else if (wr && paddr == link_regs_pkg::ctrl_offset) begin
			ctrl_word <= pwdata & link_regs_pkg::ctrl_write_mask;
		end
	end

	assign ctrl.target_local = ctrl_word[link_regs_pkg::ctrl_target_bit];
	assign ctrl.addr_compress_off = ctrl_word[link_regs_pkg::ctrl_addr_bit];
	assign ctrl.internal_wrap = ctrl_word[link_regs_pkg::ctrl_wrap_bit];
	assign ctrl.soft_reset = ctrl_word[link_regs_pkg::ctrl_soft_reset_bit];
	assign ctrl_out = ctrl;
	assign core_reset = ctrl.soft_reset;

	// Pointer register survives the software reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_pointer <= 32'h0000_0000;
		end else if (wr && paddr == link_regs_pkg::irq_pointer_offset) begin
			irq_pointer <= pwdata;
		end
	end

	// -----------------------------------------------------------------
	// Serial symbol receiver
	// -----------------------------------------------------------------
	logic [7:0] rx_shift;
	logic [2:0] rx_count;
	logic sym_valid;
	logic [7:0] sym_byte;
	logic rx_in;

	// Loopback selects internal transmit bit, external lane ignored
	assign rx_in = ctrl.internal_wrap ? link_tx_data : rx_data_s;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rx_shift <= 8'h00;
			rx_count <= 3'h0;
			sym_valid <= 1'b0;
		end else if (ctrl.soft_reset) begin
			rx_shift <= 8'h00;
			rx_count <= 3'h0;
			sym_valid <= 1'b0;
		end else begin
			sym_valid <= 1'b0;
			if (link_rise) begin
				rx_shift <= {rx_shift[6:0], rx_in};
				rx_count <= rx_count + 3'h1;
				sym_valid <= (rx_count == 3'h7);
			end
		end
	end

	assign sym_byte = rx_shift;

	// -----------------------------------------------------------------
	// Transmit shifter and loopback byte path
	// -----------------------------------------------------------------
	logic [7:0] tx_shift;
	logic [7:0] loop_q;
	logic loop_v;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tx_shift <= 8'h00;
		end else if (ctrl.soft_reset) begin
			tx_shift <= 8'h00;
		end else if (tx_byte_valid) begin
			tx_shift <= tx_byte;
		end else if (link_rise) begin
			tx_shift <= {tx_shift[6:0], 1'b0};
		end
	end

	assign link_tx_data = ctrl.soft_reset ? 1'b0 : tx_shift[7];

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			loop_q <= 8'h00;
			loop_v <= 1'b0;
		end else if (ctrl.internal_wrap && !ctrl.soft_reset) begin
			loop_q <= tx_byte;
			loop_v <= tx_byte_valid;
		end else begin
			loop_q <= core_status.rx_byte;
			loop_v <= core_status.rx_byte_valid & ~ctrl.soft_reset;
		end
	end

	assign loop_byte = loop_q;
	assign loop_byte_valid = loop_v;

	// -----------------------------------------------------------------
	// Flow control
	// -----------------------------------------------------------------
	logic in_pause;
	logic out_pause;
	logic fifo_full;
	logic [7:0] pause_sym_q;
	logic pause_sym_v;

	assign fifo_full = core_status.fifo1_full | core_status.fifo2_full;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			in_pause <= 1'b0;
		end else if (ctrl.soft_reset) begin
			in_pause <= 1'b0;
		end else if (sym_valid && sym_byte == link_regs_pkg::sym_pause_on) begin
			in_pause <= 1'b1;
		end else if (sym_valid && sym_byte == link_regs_pkg::sym_pause_off) begin
			in_pause <= 1'b0;
		end
	end

	assign tx_stall = in_pause;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			out_pause <= 1'b0;
			pause_sym_q <= 8'h00;
			pause_sym_v <= 1'b0;
		end else if (ctrl.soft_reset) begin
			out_pause <= 1'b0;
			pause_sym_q <= 8'h00;
			pause_sym_v <= 1'b0;
		end else begin
			pause_sym_v <= 1'b0;
			if (fifo_full && !out_pause) begin
				out_pause <= 1'b1;
				pause_sym_q <= link_regs_pkg::sym_pause_on;
				pause_sym_v <= 1'b1;
			end else if (!fifo_full && out_pause) begin
				out_pause <= 1'b0;
				pause_sym_q <= link_regs_pkg::sym_pause_off;
				pause_sym_v <= 1'b1;
			end
		end
	end

	assign pause_symbol = pause_sym_q;
	assign pause_symbol_valid = pause_sym_v;

	// -----------------------------------------------------------------
	// Status register
	// -----------------------------------------------------------------
	logic near_err;
	logic far_err;
	logic far_event;
	logic link_q;
	logic [3:0] rx_lanes;
	logic [3:0] tx_lanes;
	logic [2:0] sample_q;
	logic [31:0] status_word;

	assign far_event = sym_valid && (sym_byte == link_regs_pkg::sym_error);

	// Set wins over a same-cycle clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			near_err <= 1'b0;
		end else if (ctrl.soft_reset) begin
			near_err <= 1'b0;
		end else if (core_status.inbound_error) begin
			near_err <= 1'b1;
		end else if (status_write && pwdata[link_regs_pkg::st_near_err_bit]) begin
			near_err <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			far_err <= 1'b0;
		end else if (ctrl.soft_reset) begin
			far_err <= 1'b0;
		end else if (far_event) begin
			far_err <= 1'b1;
		end else if (status_write && pwdata[link_regs_pkg::st_far_err_bit]) begin
			far_err <= 1'b0;
		end
	end

	// Reserved lane counts shown as zero
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			link_q <= 1'b0;
			rx_lanes <= 4'h0;
			tx_lanes <= 4'h0;
			sample_q <= 3'h0;
		end else if (ctrl.soft_reset) begin
			link_q <= 1'b0;
			rx_lanes <= 4'h0;
			tx_lanes <= 4'h0;
			sample_q <= 3'h0;
		end else begin
			link_q <= core_status.link_up;
			rx_lanes <= (core_status.rx_lane_count > link_regs_pkg::lane_count_max) ?
				4'h0 : core_status.rx_lane_count;
			tx_lanes <= (core_status.tx_lane_count > link_regs_pkg::lane_count_max) ?
				4'h0 : core_status.tx_lane_count;
			sample_q <= core_status.rx_sample_point_now;
		end
	end

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[link_regs_pkg::st_rx_lane_lo +: 4] = rx_lanes;
		status_word[link_regs_pkg::st_tx_lane_lo +: 4] = tx_lanes;
		status_word[link_regs_pkg::st_sample_lo +: 3] = sample_q;
		status_word[link_regs_pkg::st_tuner_bit] = 1'b1;
		status_word[link_regs_pkg::st_in_pause_bit] = in_pause;
		status_word[link_regs_pkg::st_out_pause_bit] = out_pause;
		status_word[link_regs_pkg::st_far_err_bit] = far_err;
		status_word[link_regs_pkg::st_near_err_bit] = near_err;
		status_word[link_regs_pkg::st_link_bit] = link_q;
	end

	// -----------------------------------------------------------------
	// Interrupt registers
	// -----------------------------------------------------------------
	logic [2:0] irq_status;
	logic [2:0] irq_enable;
	logic [2:0] irq_events;
	logic [2:0] irq_clear;
	logic link_prev;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			link_prev <= 1'b0;
		end else begin
			link_prev <= link_q;
		end
	end

	assign irq_events[link_regs_pkg::ev_near_err] = core_status.inbound_error &
		~ctrl.soft_reset;
	assign irq_events[link_regs_pkg::ev_far_err] = far_event & ~ctrl.soft_reset;
	assign irq_events[link_regs_pkg::ev_link_change] = link_q ^ link_prev;
	assign irq_clear = (wr && paddr == link_regs_pkg::irq_clear_offset) ?
		pwdata[link_regs_pkg::ev_width-1:0] : 3'h0;

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_status <= 3'h0;
		end else begin
			irq_status <= (irq_status & ~irq_clear) | irq_events;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_enable <= 3'h0;
		end else if (wr && paddr == link_regs_pkg::irq_enable_offset) begin
			irq_enable <= pwdata[link_regs_pkg::ev_width-1:0];
		end
	end

	assign port_irq_out = |(irq_status & irq_enable);

	// -----------------------------------------------------------------
	// Read data
	// -----------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				link_regs_pkg::ctrl_offset: prdata <= ctrl_word;
				link_regs_pkg::status_offset: prdata <= status_word;
				link_regs_pkg::irq_status_offset: prdata <= {29'h0, irq_status};
				link_regs_pkg::irq_enable_offset: prdata <= {29'h0, irq_enable};
				link_regs_pkg::irq_pointer_offset: prdata <= irq_pointer;
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule // serial_link_ctrl_status
`default_nettype wire

// file: testbench/link_peer.sv
`timescale 1ns/10ps
`default_nettype none
module link_peer (
	// Serial pins
	output logic link_clk,
	output logic link_rx_data
);
	initial begin
		link_clk = 1'b0;
		link_rx_data = 1'b0;
	end
	// Clock runs only inside a symbol; data inverts when released
	task automatic send_sym(input logic [7:0] sym);
		for (int i = 7; i >= 0; i--) begin
			link_rx_data <= sym[i];
			#200 link_clk <= 1'b1;
			#200 link_clk <= 1'b0;
		end
		link_rx_data <= ~sym[0];
	endtask
endmodule // link_peer
`default_nettype wire

// file: testbench/link_regs_chk.sv
`timescale 1ns/10ps
`default_nettype none
module link_regs_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// Core side
	input wire logic [7:0] tx_byte,
	input wire logic tx_byte_valid,
	input wire link_regs_pkg::ctrl_type ctrl_out,
	input wire logic core_reset,
	input wire logic loop_byte_valid,
	input wire logic [7:0] loop_byte,
	input wire logic tx_stall,
	input wire logic link_tx_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic wr;
	logic rd;
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;

	ctrl_load_a: assert property (
		wr && paddr == link_regs_pkg::ctrl_offset |=> ctrl_out ==
		{$past(pwdata[7]), $past(pwdata[2:0])})
		else $error("control outputs differ from last write");
	soft_rst_a: assert property (
		wr && paddr == link_regs_pkg::ctrl_offset && pwdata[0]
		|=> core_reset && ctrl_out.soft_reset)
		else $error("soft reset not applied");
	tx_quiet_a: assert property (
		core_reset [*3] |-> !link_tx_data)
		else $error("serial output active in soft reset");
	stall_clr_a: assert property (
		core_reset [*3] |-> !tx_stall)
		else $error("stall kept through soft reset");
	wrap_pass_a: assert property (
		tx_byte_valid && ctrl_out.internal_wrap
		|=> loop_byte_valid && loop_byte == $past(tx_byte))
		else $error("wrapped byte lost");
	wrap_only_a: assert property (
		ctrl_out.internal_wrap && !tx_byte_valid |=> !loop_byte_valid)
		else $error("external byte seen in wrap");
	ctrl_rsvd_a: assert property (
		rd && paddr == link_regs_pkg::ctrl_offset
		|-> (prdata & ~link_regs_pkg::ctrl_write_mask) == 32'h0)
		else $error("control reserved bits not zero");
	stat_fixed_a: assert property (
		rd && paddr == link_regs_pkg::status_offset
		|-> prdata[31:28] == 4'h0 && prdata[19:15] == 5'h00 && prdata[11])
		else $error("status fixed bits wrong");

	cover property (wr && paddr == link_regs_pkg::ctrl_offset && pwdata[0]);
	cover property (tx_byte_valid && ctrl_out.internal_wrap);
	cover property ($rose(tx_stall));
endmodule // link_regs_chk

bind serial_link_ctrl_status link_regs_chk chk (.clk, .resetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .prdata, .tx_byte, .tx_byte_valid,
	.ctrl_out, .core_reset, .loop_byte_valid, .loop_byte, .tx_stall,
	.link_tx_data);
`default_nettype wire

// file: testbench/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin \
	err_total++; $display("BAD %0t got %h want %h", $time, g, e); end end
module tb;
	localparam logic [7:0] a_ctl = link_regs_pkg::ctrl_offset;
	localparam logic [7:0] a_st = link_regs_pkg::status_offset;
	localparam logic [7:0] a_is = link_regs_pkg::irq_status_offset;
	localparam logic [7:0] a_ic = link_regs_pkg::irq_clear_offset;
	localparam logic [7:0] a_ie = link_regs_pkg::irq_enable_offset;
	localparam logic [7:0] a_ip = link_regs_pkg::irq_pointer_offset;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr, tx_byte, loop_byte, pause_symbol;
	logic [31:0] pwdata, prdata, irq_pointer, rd;
	logic link_clk, link_rx_data, link_tx_data, tx_byte_valid, tx_stall;
	logic loop_byte_valid, pause_symbol_valid, port_irq_out, core_reset;
	link_regs_pkg::core_status_type core_status;
	link_regs_pkg::ctrl_type ctrl_out;
	int err_total, n_compared;

	serial_link_ctrl_status dut (.clk, .resetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .link_clk,
		.link_rx_data, .link_tx_data, .core_status, .tx_byte, .tx_byte_valid,
		.ctrl_out, .irq_pointer, .core_reset, .loop_byte_valid, .loop_byte,
		.tx_stall, .pause_symbol, .pause_symbol_valid, .port_irq_out);
	link_peer peer (.link_clk, .link_rx_data);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// --------
	// Bus tasks
	// --------
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		rd = prdata;
		err = pslverr;
		if (n >= 16) err_total++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		`CHK(rd, e)
	endtask
	task automatic settle();
		repeat (6) @(posedge clk);
	endtask
	task automatic err_pulse();
		core_status.inbound_error <= 1'b1;
		@(posedge clk);
		core_status.inbound_error <= 1'b0;
	endtask

	// --------
	// Scenarios
	// --------
	task automatic t_reset();
		rdc(a_ctl, 32'h0);
		rdc(a_st, 32'h0000_0800);
		wr(8'h40, 32'hFFFF_FFFF);
		`CHK(err, 1'b1)
		rdc(8'h40, 32'h0);
		`CHK(err, 1'b1)
		$display("reset test done");
	endtask
	task automatic t_ctrl();
		wr(a_ctl, 32'hFFFF_FFFE);
		rdc(a_ctl, 32'h0000_0086);
		`CHK(ctrl_out, 4'b1110)
		wr(a_ctl, 32'h0000_0080);
		wr(a_ip, {24'h0, a_is});
		`CHK(irq_pointer, {24'h0, a_is})
		rdc(a_ctl, 32'h0000_0080);
		`CHK(ctrl_out, 4'b1000)
		$display("control test done");
	endtask
	task automatic wait_pause(input logic [7:0] e);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (pause_symbol_valid !== 1'b1 && n < 16);
		`CHK(pause_symbol_valid, 1'b1)
		`CHK(pause_symbol, e)
		@(posedge clk);
	endtask
	task automatic t_status();
		core_status.rx_lane_count <= 4'h4;
		core_status.tx_lane_count <= 4'h3;
		core_status.rx_sample_point_now <= 3'h5;
		core_status.link_up <= 1'b1;
		core_status.fifo1_full <= 1'b1;
		wait_pause(link_regs_pkg::sym_pause_on);
		settle();
		rdc(a_st, 32'h0430_5A01);
		wr(a_st, 32'hFFFF_FFFF);
		rdc(a_st, 32'h0430_5A01);
		core_status.rx_lane_count <= 4'h5;
		core_status.tx_lane_count <= 4'hF;
		core_status.link_up <= 1'b0;
		core_status.fifo1_full <= 1'b0;
		core_status.fifo2_full <= 1'b1;
		settle();
		rdc(a_st, 32'h0000_5A00);
		core_status <= '0;
		wait_pause(link_regs_pkg::sym_pause_off);
		settle();
		rdc(a_st, 32'h0000_0800);
		$display("status test done");
	endtask
	task automatic t_flow();
		peer.send_sym(link_regs_pkg::sym_pause_on);
		settle();
		rdc(a_st, 32'h0000_0C00);
		`CHK(tx_stall, 1'b1)
		peer.send_sym(link_regs_pkg::sym_pause_off);
		settle();
		rdc(a_st, 32'h0000_0800);
		`CHK(tx_stall, 1'b0)
		$display("flow test done");
	endtask
	task automatic t_err();
		wr(a_ie, 32'h0);
		err_pulse();
		settle();
		rdc(a_st, 32'h0000_0880);
		@(negedge clk);
		`CHK(port_irq_out, 1'b0)
		@(posedge clk);
		wr(a_ie, 32'h3);
		@(negedge clk);
		`CHK(port_irq_out, 1'b1)
		peer.send_sym(link_regs_pkg::sym_error);
		settle();
		rdc(a_st, 32'h0000_0980);
		wr(a_st, 32'h0);
		rdc(a_st, 32'h0000_0980);
		wr(a_st, 32'h0000_0080);
		rdc(a_st, 32'h0000_0900);
		rdc(a_is, 32'h7);
		wr(a_ic, 32'h7);
		rdc(a_is, 32'h0);
		@(negedge clk);
		`CHK(port_irq_out, 1'b0)
		@(posedge clk);
		wr(a_st, 32'h0000_0100);
		rdc(a_st, 32'h0000_0800);
		$display("error test done");
	endtask
	task automatic t_wrap(input logic [31:0] c, input logic [7:0] e);
		wr(a_ctl, c);
		tx_byte <= 8'hA5;
		tx_byte_valid <= 1'b1;
		core_status.rx_byte <= 8'h3C;
		core_status.rx_byte_valid <= 1'b1;
		@(posedge clk);
		tx_byte_valid <= 1'b0;
		core_status.rx_byte_valid <= 1'b0;
		@(negedge clk);
		`CHK(loop_byte_valid, 1'b1)
		`CHK(loop_byte, e)
		@(posedge clk);
		$display("wrap test done");
	endtask
	task automatic t_soft();
		peer.send_sym(link_regs_pkg::sym_pause_on);
		@(posedge clk);
		err_pulse();
		wr(a_ip, 32'h1234_5678);
		wr(a_ctl, 32'h0000_0085);
		settle();
		rdc(a_st, 32'h0000_0800);
		rdc(a_ctl, 32'h0000_0085);
		rdc(a_ip, 32'h1234_5678);
		`CHK(irq_pointer, 32'h1234_5678)
		rdc(a_is, 32'h1);
		@(negedge clk);
		`CHK(core_reset, 1'b1)
		`CHK(link_tx_data, 1'b0)
		`CHK(tx_stall, 1'b0)
		@(posedge clk);
		wr(a_ctl, 32'h0000_0080);
		wr(a_ic, 32'h7);
		$display("soft reset test done");
	endtask

	task automatic end_sim();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#500000;
		err_total++;
		end_sim();
	end

	initial begin
		err_total = 0;
		n_compared = 0;
		resetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		core_status = '0;
		tx_byte = 8'h00;
		tx_byte_valid = 1'b0;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		t_reset();
		t_ctrl();
		t_status();
		t_flow();
		t_err();
		t_wrap(32'h0000_0082, 8'hA5);
		t_wrap(32'h0000_0080, 8'h3C);
		t_soft();
		end_sim();
	end
endmodule // tb
`default_nettype wire
